// ==== verilog/dbgd_pkg.sv ====
package dbgd_pkg;

  // clock and refresh timing
  localparam int CLK_KHZ = 100000;
  localparam int REFRESH_PERIOD_NS = 15630;
  localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS * (CLK_KHZ / 1000) / 1000;
  localparam logic [7:0] REFRESH_TIMER_VAL = 8'h49;

  // device access times and the wait states they need
  localparam int SRAM_ACCESS_NS = 85;
  localparam int FLASH_ACCESS_NS = 90;
  localparam int DPRAM_ACCESS_NS = 25;
  localparam logic [2:0] FLASH_WAIT = 3'h4;
  localparam logic [2:0] SRAM_WAIT = 3'h4;
  localparam logic [2:0] DPRAM_WAIT = 3'h2;
  localparam logic [2:0] SDRAM_WAIT = 3'h0;
  localparam logic [2:0] LCD_WAIT = 3'h0;

  // on-board memory map
  localparam logic [31:0] FLASH_BASE = 32'hFFC00000;
  localparam logic [31:0] SRAM_BASE = 32'h04000000;
  localparam logic [31:0] SRAM_LAST = 32'h040FFFFF;
  localparam logic [31:0] DPRAM_BASE = 32'h04400000;
  localparam logic [31:0] DPRAM_LAST = 32'h04401FFF;
  localparam logic [31:0] SDRAM_BASE = 32'h00000000;
  localparam logic [31:0] SDRAM_LAST = 32'h00FFFFFF;
  localparam logic [31:0] LCD_BASE = 32'h05200000;
  localparam logic [31:0] LCD_LAST = 32'h053FFFFF;

  // dedicated port bit positions
  localparam int PORT_BUSY_BIT = 14;
  localparam int PORT_SEM_BIT = 13;
  localparam int PORT_SERIAL_BIT = 11;
  localparam int PORT_PFAIL_BIT = 10;
  localparam int PORT_PANEL_BIT = 8;

  // host address match patterns, bits 22:20 and 19:16
  localparam logic [2:0] BOARD_MATCH = 3'h5;
  localparam logic [3:0] DPRAM_MATCH = 4'hC;

  // reset values
  localparam logic [7:0] PIN_IDLE = 8'hFF;
  localparam logic [7:0] CS_IDLE = 8'hFF;

  typedef struct packed {
    logic [2:0] spare_n;
    logic panel_ctrl_select_n;
    logic sync_dram_select_n;
    logic shared_mem_select_n;
    logic static_ram_select_n;
    logic boot_flash_select_n;
  } dbgd_cs_type;

  typedef struct packed {
    logic memory_space_qualifier;
    logic [22:16] addr;
    logic host_read_write;
    logic host_lower_strobe;
    logic host_upper_strobe;
  } dbgd_host_in_type;

  typedef struct packed {
    logic host_transfer_ack;
    logic shared_mem_write_strobe;
    logic shared_mem_chip_sel;
    logic host_irq_level_six;
    logic valid_peripheral_ack;
    logic buffer_direction;
  } dbgd_host_out_type;

  localparam dbgd_host_in_type HOST_IN_IDLE = 11'h007;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_FLASH = 3'b001,
    REG_SRAM = 3'b010,
    REG_DPRAM = 3'b011,
    REG_SDRAM = 3'b100,
    REG_LCD = 3'b101
  } dbgd_region_type;

endpackage

// ==== verilog/dbgd_top.sv ====
`timescale 1ns/100ps

module dbgd_top #(
  parameter int REFRESH_CYCLES = dbgd_pkg::REFRESH_CYCLES
) (
  input wire logic clk, // on-board clock, 100 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic host_bus_clock, // host bus clock
  input wire dbgd_pkg::dbgd_host_in_type host_in, // host address and strobes
  input wire logic shared_mem_irq_n, // shared memory interrupt, low active
  input wire logic host_irq_ack_six, // host level six acknowledge, low
  output dbgd_pkg::dbgd_host_out_type host_out, // host side strobes
  output logic host_access_pulse, // one pulse per decoded host cycle
  input wire logic [31:0] proc_addr, // on-board processor address
  input wire logic boot_mem_enable_n, // boot memory enable
  input wire logic second_mem_enable_n, // second memory enable
  input wire logic third_mem_enable_n, // third memory enable
  input wire logic flash_addr_bit9, // address decode input nine
  input wire logic shared_mem_busy_in, // shared memory busy
  input wire logic serial_level_valid, // serial receiver level valid
  input wire logic power_fail_in, // power fail comparator
  input wire logic panel_type_in, // panel type strap
  input wire logic semaphore_req, // semaphore request, same clock
  output logic flash_upper_bank_sel, // upper flash bank select
  output logic flash_lower_bank_sel, // lower flash bank select
  output logic data_buffer_enable, // shared data buffer enable
  output dbgd_pkg::dbgd_cs_type mem_selects, // chip selects 0..7, low
  output logic [2:0] wait_states, // wait states of current region
  output logic refresh_tick, // one pulse per refresh interval
  output logic [7:0] refresh_period_timer, // refresh timer setting
  output logic [15:0] port_status, // dedicated port image
  output logic semaphore_set_out // semaphore set strobe
);

  generate
    if (REFRESH_CYCLES < 8 || REFRESH_CYCLES > 65535)
    begin : g_bad_refresh
      $error("refresh count out of range");
    end
  endgenerate

  function automatic dbgd_pkg::dbgd_region_type region_of(
    input logic [31:0] a
  );
    region_of = dbgd_pkg::REG_NONE;
    if (a >= dbgd_pkg::FLASH_BASE)
      region_of = dbgd_pkg::REG_FLASH;
    else if (a >= dbgd_pkg::SRAM_BASE && a <= dbgd_pkg::SRAM_LAST)
      region_of = dbgd_pkg::REG_SRAM;
    else if (a >= dbgd_pkg::DPRAM_BASE && a <= dbgd_pkg::DPRAM_LAST)
      region_of = dbgd_pkg::REG_DPRAM;
    else if (a <= dbgd_pkg::SDRAM_LAST)
      region_of = dbgd_pkg::REG_SDRAM;
    else if (a >= dbgd_pkg::LCD_BASE && a <= dbgd_pkg::LCD_LAST)
      region_of = dbgd_pkg::REG_LCD;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // on-board clock domain: pin synchronisers

  logic [7:0] pin_raw;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [31:0] addr_s1_r;
  logic [31:0] addr_s2_r;
  logic ce0;
  logic ce1;
  logic ce2;
  logic a9;

  assign pin_raw = {boot_mem_enable_n, second_mem_enable_n,
    third_mem_enable_n, flash_addr_bit9, shared_mem_busy_in,
    serial_level_valid, power_fail_in, panel_type_in};
  assign ce0 = pin_s2_r[7];
  assign ce1 = pin_s2_r[6];
  assign ce2 = pin_s2_r[5];
  assign a9 = pin_s2_r[4];

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pin_s1_r <= dbgd_pkg::PIN_IDLE;
      pin_s2_r <= dbgd_pkg::PIN_IDLE;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      addr_s1_r <= proc_addr;
      addr_s2_r <= addr_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash bank split and data buffer enable

  logic upper_r;
  logic lower_r;
  logic dbe_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      upper_r <= 1'b0;
      lower_r <= 1'b0;
      dbe_r <= 1'b1;
    end
    else
    begin
      upper_r <= a9 & ~ce0;
      lower_r <= ~a9 & ~ce0;
      dbe_r <= ce0 & ce1 & ce2;
    end
  end

  assign flash_upper_bank_sel = upper_r;
  assign flash_lower_bank_sel = lower_r;
  assign data_buffer_enable = dbe_r;

  ////////////////////////////////////////////////////////////////////////////
  // chip select assignment and wait states

  dbgd_pkg::dbgd_region_type region;
  dbgd_pkg::dbgd_cs_type cs_nxt;
  logic [2:0] wait_nxt;
  dbgd_pkg::dbgd_cs_type cs_r;
  logic [2:0] wait_r;

  always_comb
  begin
    region = region_of(addr_s2_r);
    cs_nxt = dbgd_pkg::CS_IDLE;
    wait_nxt = 3'h0;
    unique case (region)
      dbgd_pkg::REG_FLASH:
      begin
        cs_nxt.boot_flash_select_n = 1'b0;
        wait_nxt = dbgd_pkg::FLASH_WAIT;
      end
      dbgd_pkg::REG_SRAM:
      begin
        cs_nxt.static_ram_select_n = 1'b0;
        wait_nxt = dbgd_pkg::SRAM_WAIT;
      end
      dbgd_pkg::REG_DPRAM:
      begin
        cs_nxt.shared_mem_select_n = 1'b0;
        wait_nxt = dbgd_pkg::DPRAM_WAIT;
      end
      dbgd_pkg::REG_SDRAM:
      begin
        cs_nxt.sync_dram_select_n = 1'b0;
        wait_nxt = dbgd_pkg::SDRAM_WAIT;
      end
      dbgd_pkg::REG_LCD:
      begin
        cs_nxt.panel_ctrl_select_n = 1'b0;
        wait_nxt = dbgd_pkg::LCD_WAIT;
      end
      dbgd_pkg::REG_NONE:
      begin
        cs_nxt = dbgd_pkg::CS_IDLE;
      end
      default:
      begin
        cs_nxt = dbgd_pkg::CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cs_r <= dbgd_pkg::CS_IDLE;
      wait_r <= 3'h0;
    end
    else
    begin
      cs_r <= cs_nxt;
      wait_r <= wait_nxt;
    end
  end

  assign mem_selects = cs_r;
  assign wait_states = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // refresh interval timer

  logic [15:0] refresh_cnt_r;
  logic tick_r;
  logic [7:0] timer_val_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      refresh_cnt_r <= 16'(REFRESH_CYCLES - 1);
      tick_r <= 1'b0;
      timer_val_r <= 8'h00;
    end
    else
    begin
      timer_val_r <= dbgd_pkg::REFRESH_TIMER_VAL;
      if (refresh_cnt_r == 16'h0000)
      begin
        refresh_cnt_r <= 16'(REFRESH_CYCLES - 1);
        tick_r <= 1'b1;
      end
      else
      begin
        refresh_cnt_r <= refresh_cnt_r - 16'h0001;
        tick_r <= 1'b0;
      end
    end
  end

  assign refresh_tick = tick_r;
  assign refresh_period_timer = timer_val_r;

  ////////////////////////////////////////////////////////////////////////////
  // dedicated port image and semaphore strobe

  logic [15:0] port_r;
  logic sem_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      port_r <= 16'h0000;
      sem_r <= 1'b0;
    end
    else
    begin
      sem_r <= semaphore_req;
      port_r <= 16'h0000;
      port_r[dbgd_pkg::PORT_BUSY_BIT] <= pin_s2_r[3];
      port_r[dbgd_pkg::PORT_SEM_BIT] <= semaphore_req;
      port_r[dbgd_pkg::PORT_SERIAL_BIT] <= pin_s2_r[2];
      port_r[dbgd_pkg::PORT_PFAIL_BIT] <= pin_s2_r[1];
      port_r[dbgd_pkg::PORT_PANEL_BIT] <= pin_s2_r[0];
    end
  end

  assign port_status = port_r;
  assign semaphore_set_out = sem_r;

  ////////////////////////////////////////////////////////////////////////////
  // host clock domain: reset and pin synchronisers

  logic hrst_s1_r;
  logic hrst_s2_r;
  dbgd_pkg::dbgd_host_in_type hin_s1_r;
  dbgd_pkg::dbgd_host_in_type hin_s2_r;
  logic [1:0] hirq_s1_r;
  logic [1:0] hirq_s2_r;
  logic cycle_end_r;

  always_ff @(posedge host_bus_clock)
  begin
    hrst_s1_r <= rstn;
    hrst_s2_r <= hrst_s1_r;
  end

  always_ff @(posedge host_bus_clock)
  begin
    if (!hrst_s2_r)
    begin
      hin_s1_r <= dbgd_pkg::HOST_IN_IDLE;
      hin_s2_r <= dbgd_pkg::HOST_IN_IDLE;
      hirq_s1_r <= 2'h3;
      hirq_s2_r <= 2'h3;
      cycle_end_r <= 1'b1;
    end
    else
    begin
      hin_s1_r <= host_in;
      hin_s2_r <= hin_s1_r;
      hirq_s1_r <= {shared_mem_irq_n, host_irq_ack_six};
      hirq_s2_r <= hirq_s1_r;
      cycle_end_r <= hin_s2_r.host_read_write & hin_s2_r.host_lower_strobe
        & hin_s2_r.host_upper_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // board select, acknowledge and shared memory strobes

  logic bs_nxt;
  logic bs_r;
  logic ack_r;
  logic wr_n_r;
  logic sel_n_r;

  assign bs_nxt = hin_s2_r.memory_space_qualifier
    & (hin_s2_r.addr[22:20] == dbgd_pkg::BOARD_MATCH);

  // the end of a host cycle clears the decode without waiting for a clock
  always_ff @(posedge host_bus_clock or posedge cycle_end_r)
  begin
    if (cycle_end_r)
    begin
      bs_r <= 1'b0;
      ack_r <= 1'b0;
      wr_n_r <= 1'b1;
      sel_n_r <= 1'b1;
    end
    else if (!hrst_s2_r)
    begin
      bs_r <= 1'b0;
      ack_r <= 1'b0;
      wr_n_r <= 1'b1;
      sel_n_r <= 1'b1;
    end
    else
    begin
      bs_r <= bs_nxt;
      ack_r <= bs_r;
      wr_n_r <= ~(bs_nxt & ~bs_r & hin_s2_r.host_read_write);
      sel_n_r <= ~(bs_nxt
        & (hin_s2_r.addr[19:16] == dbgd_pkg::DPRAM_MATCH)
        & ~hin_s2_r.host_lower_strobe);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt handshake and buffer direction

  logic host_irq_level_six_r;
  logic vpa_r;
  logic dir_r;

  always_ff @(posedge host_bus_clock)
  begin
    if (!hrst_s2_r)
    begin
      host_irq_level_six_r <= 1'b0;
      vpa_r <= 1'b0;
      dir_r <= 1'b0;
    end
    else
    begin
      host_irq_level_six_r <= ~hirq_s2_r[1];
      vpa_r <= ~hirq_s2_r[1] & ~hirq_s2_r[0];
      dir_r <= ~hin_s2_r.host_read_write;
    end
  end

  assign host_out = '{host_transfer_ack: ack_r,
    shared_mem_write_strobe: wr_n_r, shared_mem_chip_sel: sel_n_r,
    host_irq_level_six: host_irq_level_six_r, valid_peripheral_ack: vpa_r,
    buffer_direction: dir_r};

  ////////////////////////////////////////////////////////////////////////////
  // host cycle event toward the on-board clock

  logic host_tog_r;
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_s3_r;
  logic access_r;

  always_ff @(posedge host_bus_clock)
  begin
    if (!hrst_s2_r)
      host_tog_r <= 1'b0;
    else if (bs_nxt && !bs_r && !cycle_end_r)
      host_tog_r <= ~host_tog_r;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      access_r <= 1'b0;
    end
    else
    begin
      tog_s1_r <= host_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      access_r <= tog_s2_r ^ tog_s3_r;
    end
  end

  assign host_access_pulse = access_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_sel_rise;
    !bs_r ##1 bs_r;
  endsequence

  property p_ack_follows;
    @(posedge host_bus_clock) disable iff (!hrst_s2_r || cycle_end_r)
      s_sel_rise |=> ack_r;
  endproperty

  a_ack_delay: assert property (p_ack_follows)
    else $error("acknowledge did not follow board select");

  a_write_strobe: assert property (@(posedge host_bus_clock)
    disable iff (!hrst_s2_r) !wr_n_r |-> bs_r && !ack_r)
    else $error("write strobe outside first select cycle");

  a_mem_sel: assert property (@(posedge host_bus_clock)
    disable iff (!hrst_s2_r) !sel_n_r |-> bs_r)
    else $error("shared memory select without board select");

  a_vpa_irq: assert property (@(posedge host_bus_clock)
    disable iff (!hrst_s2_r) vpa_r |-> host_irq_level_six_r)
    else $error("peripheral ack without level six request");

  a_dir_invert: assert property (@(posedge host_bus_clock)
    disable iff (!hrst_s2_r)
    $past(hrst_s2_r) |-> dir_r == !$past(hin_s2_r.host_read_write))
    else $error("buffer direction not inverted");

  a_bs_cleared: assert property (@(posedge host_bus_clock)
    disable iff (!hrst_s2_r) cycle_end_r |-> !bs_r && !ack_r)
    else $error("board select held through cycle end");

  a_flash_banks: assert property (@(posedge clk)
    disable iff (!rstn)
    (upper_r || lower_r) |-> !dbe_r && !(upper_r && lower_r))
    else $error("flash bank select with buffer idle");

  a_cs_onehot: assert property (@(posedge clk)
    disable iff (!rstn) $onehot0(~cs_r) && (&cs_r.spare_n))
    else $error("more than one chip select active");

  a_wait_sram: assert property (@(posedge clk)
    disable iff (!rstn) !cs_r.static_ram_select_n |-> wait_r == 3'h4)
    else $error("static ram wait states wrong");

  a_wait_dpram: assert property (@(posedge clk)
    disable iff (!rstn) !cs_r.shared_mem_select_n |-> wait_r == 3'h2)
    else $error("shared memory wait states wrong");

  a_refresh_gap: assert property (@(posedge clk)
    disable iff (!rstn)
    tick_r |-> refresh_cnt_r == 16'(REFRESH_CYCLES - 1) ##1 !tick_r [*7])
    else $error("refresh interval wrong");

  a_access_once: assert property (@(posedge clk)
    disable iff (!rstn) access_r |=> !access_r)
    else $error("host access pulse longer than one cycle");

endmodule

// ==== test/dbgd_host_model.sv ====
`timescale 1ns/100ps
module dbgd_host_model (
  input wire logic host_bus_clock, // host bus clock
  input wire dbgd_pkg::dbgd_host_out_type host_out, // board answers
  output dbgd_pkg::dbgd_host_in_type host_in // host address and strobes
);
  logic got_ack, saw_wr, saw_sel, cleared, dir, wr_late;

  initial host_in = dbgd_pkg::HOST_IN_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // one host cycle: hold everything until one clock after acknowledge or after 13 clocks, then release
  task automatic run(input logic q, input logic [6:0] a, input logic rw,
                     input logic lds);
    int n;
    got_ack = 1'b0;
    saw_wr = 1'b0;
    saw_sel = 1'b0;
    cleared = 1'b0;
    @(posedge host_bus_clock);
    host_in <= {q, a, rw, lds, 1'b0};
    for (n = 0; n < 12 && !got_ack; n++)
    begin
      @(posedge host_bus_clock);
      if (host_out.shared_mem_write_strobe === 1'b0)
        saw_wr = 1'b1;
      if (host_out.shared_mem_chip_sel === 1'b0)
        saw_sel = 1'b1;
      if (host_out.host_transfer_ack === 1'b1)
        got_ack = 1'b1;
    end
    dir = host_out.buffer_direction;
    @(posedge host_bus_clock);
    wr_late = host_out.shared_mem_write_strobe;
    // released address lines show the inverse, not the last value
    host_in <= {1'b0, ~a, 3'b111};
    for (n = 0; n < 8 && !cleared; n++)
    begin
      @(posedge host_bus_clock);
      if (host_out.host_transfer_ack === 1'b0 &&
          host_out.shared_mem_chip_sel === 1'b1)
        cleared = 1'b1;
    end
    repeat (4) @(posedge host_bus_clock);
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  localparam int RC = 8;
  logic clk = 1'b0;
  logic host_bus_clock = 1'b0;
  logic rstn = 1'b0;
  logic irq_n = 1'b1, iack_n = 1'b1;
  logic [31:0] proc_addr = 32'h00000000;
  logic boot_n = 1'b1, second_n = 1'b1, third_n = 1'b1, bit9 = 1'b0;
  logic busy = 1'b0, serial = 1'b0, pfail = 1'b1, panel = 1'b1;
  logic sem_req = 1'b0;
  dbgd_pkg::dbgd_host_in_type host_in;
  dbgd_pkg::dbgd_host_out_type host_out;
  dbgd_pkg::dbgd_cs_type mem_selects;
  logic pulse, upper, lower, dbe, tick, sem_out;
  logic [2:0] wait_states;
  logic [7:0] timer;
  logic [15:0] port_status, pexp;
  int error_cnt = 0, n_tests = 0, pulse_cnt = 0, ticks;
  logic [31:0] ra [8] = '{32'hFFC00000, 32'h04000000, 32'h04400000,
    32'h04401FFF, 32'h04402000, 32'h00FFFFFC, 32'h053FFFFF, 32'h06000000};
  logic [7:0] rcs [8] = '{8'hFE, 8'hFD, 8'hFB, 8'hFB, 8'hFF, 8'hF7, 8'hEF,
    8'hFF};
  logic [2:0] rws [8] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
  // host cycle table: space, address 22:16, rw, lower strobe, ack, select
  logic [11:0] hc [7] = '{{1'b1, 7'h5C, 4'b1011}, {1'b1, 7'h5C, 4'b0011},
    {1'b1, 7'h5C, 4'b1110}, {1'b1, 7'h58, 4'b1010}, {1'b0, 7'h5C, 4'b1000},
    {1'b1, 7'h4C, 4'b1000}, {1'b1, 7'h7C, 4'b1000}};

  always #5 clk = ~clk;
  always #62.5 host_bus_clock = ~host_bus_clock;

  dbgd_top #(.REFRESH_CYCLES(RC)) DUT (
    .clk(clk), .rstn(rstn), .host_bus_clock(host_bus_clock),
    .host_in(host_in), .shared_mem_irq_n(irq_n),
    .host_irq_ack_six(iack_n), .host_out(host_out),
    .host_access_pulse(pulse), .proc_addr(proc_addr),
    .boot_mem_enable_n(boot_n), .second_mem_enable_n(second_n),
    .third_mem_enable_n(third_n), .flash_addr_bit9(bit9),
    .shared_mem_busy_in(busy), .serial_level_valid(serial),
    .power_fail_in(pfail), .panel_type_in(panel), .semaphore_req(sem_req),
    .flash_upper_bank_sel(upper), .flash_lower_bank_sel(lower),
    .data_buffer_enable(dbe), .mem_selects(mem_selects),
    .wait_states(wait_states), .refresh_tick(tick),
    .refresh_period_timer(timer), .port_status(port_status),
    .semaphore_set_out(sem_out)
  );

  dbgd_host_model u_host (
    .host_bus_clock(host_bus_clock), .host_out(host_out), .host_in(host_in)
  );

  always @(posedge clk)
    if (pulse === 1'b1)
      pulse_cnt <= pulse_cnt + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #300000;
    error_cnt++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge host_bus_clock);
    check(host_out.host_transfer_ack, 1'b0);
    check(host_out.shared_mem_write_strobe, 1'b1);
    check(mem_selects, 8'hFF);
    @(posedge clk) rstn <= 1'b1;
    repeat (5) @(posedge host_bus_clock);
    // chip selects and wait states per region
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) proc_addr <= ra[i];
      repeat (4) @(posedge clk);
      check(mem_selects, rcs[i]);
      check(wait_states, rws[i]);
    end
    // flash banks and buffer enable over all enable patterns
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk) {bit9, boot_n, second_n, third_n} <= 4'(i);
      repeat (4) @(posedge clk);
      check(upper, bit9 & !boot_n);
      check(lower, !bit9 & !boot_n);
      check(dbe, boot_n & second_n & third_n);
    end
    // dedicated port inputs, both polarities
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk)
      begin
        busy <= i[0];
        sem_req <= ~i[0];
        serial <= i[0];
        pfail <= ~i[0];
        panel <= i[0];
      end
      pexp = {1'b0, i[0], ~i[0], 1'b0, i[0], ~i[0], 1'b0, i[0], 8'h00};
      repeat (4) @(posedge clk);
      check(port_status, pexp);
      check(sem_out, !i[0]);
    end
    ticks = 0;
    for (int i = 0; i < 10 * RC; i++)
    begin
      @(posedge clk);
      if (tick === 1'b1)
        ticks++;
    end
    check(ticks, 10);
    check(timer, 8'h49);
    // interrupt request and valid peripheral acknowledge
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) {irq_n, iack_n} <= 2'(i);
      repeat (6) @(posedge host_bus_clock);
      check(host_out.host_irq_level_six, !irq_n);
      check(host_out.valid_peripheral_ack, !irq_n & !iack_n);
    end
    // host cycles, decoded and ignored
    for (int i = 0; i < 7; i++)
    begin
      u_host.run(hc[i][11], hc[i][10:4], hc[i][3], hc[i][2]);
      check(u_host.got_ack, hc[i][1]);
      check(u_host.saw_wr, hc[i][1] & hc[i][3]);
      check(u_host.saw_sel, hc[i][0]);
      check(u_host.dir, !hc[i][3]);
      check(u_host.wr_late, 1'b1);
      check(u_host.cleared, 1'b1);
    end
    check(pulse_cnt, 4);
    finish_test();
  end
endmodule
